// File: bench/monitor_converter_and_output_trim_props.sv
`timescale 1ns/1ps
`default_nettype none

module mon_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire mon_pkg::trim_s trim,
    input wire logic monitor_rate_select,
    input wire logic conversion_active
);
    logic [14:0] act_cnt;
    logic setup;
    logic wr_acc;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_cnt <= '0;
        end else begin
            act_cnt <= conversion_active ? act_cnt + 15'h1 : '0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_pready_setup;
        setup |=> pready && psel && penable;
    endproperty
    a_pready_setup: assert property (p_pready_setup) else $error("no answer");
    property p_pready_cause;
        pready |-> $past(setup);
    endproperty
    a_pready_cause: assert property (p_pready_cause) else $error("bad ready");
    property p_err_unmapped;
        setup && paddr == 12'h07C |=> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("no error");
    property p_start;
        wr_acc && paddr == 12'h06C && pwdata[0] && !conversion_active
            |=> conversion_active;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    // A range allows for the register stages at the start and end edges.
    property p_conv_len;
        $fell(conversion_active) |-> (act_cnt >= 15'h06A3 &&
            act_cnt <= 15'h06A6) || (act_cnt >= 15'h351F &&
            act_cnt <= 15'h3522);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("bad length");
    property p_rate;
        wr_acc && paddr == 12'h06C |=> monitor_rate_select == $past(pwdata[1]);
    endproperty
    a_rate: assert property (p_rate) else $error("rate not taken");
    property p_done_low;
        setup && !pwrite && paddr == 12'h070 && conversion_active
            |=> prdata[0] == 1'b0;
    endproperty
    a_done_low: assert property (p_done_low) else $error("done high");
    property p_cm;
        wr_acc && paddr == 12'h060
            |=> trim.amp_input_cm_current == $past(pwdata[3:0]);
    endproperty
    a_cm: assert property (p_cm) else $error("cm trim wrong");
    property p_offset;
        wr_acc && paddr == 12'h064
            |=> trim.output_dc_offset_trim == $past(pwdata[7:0]);
    endproperty
    a_offset: assert property (p_offset) else $error("offset wrong");
endmodule : mon_props

bind monitor_converter_and_output_trim mon_props u_mon_props (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .trim, .monitor_rate_select, .conversion_active);

`default_nettype wire

// File: bench/monitor_converter_and_output_trim_test.sv
`timescale 1ns/1ps
`default_nettype none

module monitor_converter_and_output_trim_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0] sample_code = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, monitor_rate_select, conversion_active, irq;
    mon_pkg::trim_s trim;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;

    monitor_converter_and_output_trim u_monitor_converter_and_output_trim (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_code(sample_code),
        .trim(trim), .monitor_rate_select(monitor_rate_select),
        .conversion_active(conversion_active), .irq(irq));

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    // The slow conversion alone needs about 13600 cycles.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 25000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    task automatic final_report;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // A spare idle cycle after each transfer keeps drives one per time step.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h00000000, q, e);
        check(nm, q, x);
    endtask : rd

    task automatic t_reset;
        rd("cm", 12'h060, 32'h00000000);
        rd("offset", 12'h064, 32'h000000A0);
        rd("ctrl", 12'h06C, 32'h00000000);
        rd("done", 12'h070, 32'h00000001);
        rd("result", 12'h074, 32'h000000BD);
        rd("status", 12'h080, 32'h00000000);
        check("trim", 32'(trim), 32'h000000A0);
    endtask : t_reset

    task automatic t_trim;
        logic [31:0] q;
        logic e;
        wr(12'h060, 32'h000000FF);
        rd("cm", 12'h060, 32'h0000000F);
        wr(12'h064, 32'h0000005C);
        rd("offset", 12'h064, 32'h0000005C);
        check("trim", 32'(trim), 32'h00000F5C);
        wr(12'h074, 32'h00000000);
        rd("result", 12'h074, 32'h000000BD);
        wr(12'h070, 32'h00000000);
        rd("done", 12'h070, 32'h00000001);
        apb(1'b0, 12'h07C, 32'h00000000, q, e);
        check("unmapped", {e, q[30:0]}, 32'h80000000);
    endtask : t_trim

    task automatic wait_conv(input int len, input int t0);
        while (conversion_active === 1'b1) @(posedge pclk);
        check("len", 32'(cycles - t0 >= len - 3 && cycles - t0 <= len + 2),
              32'h00000001);
    endtask : wait_conv

    task automatic t_fast;
        int t0;
        wr(12'h084, 32'h00000001);
        sample_code <= 8'h5A;
        wr(12'h06C, 32'h00000001);
        t0 = cycles;
        check("rate", 32'(monitor_rate_select), 32'h00000000);
        check("active", 32'(conversion_active), 32'h00000001);
        rd("done", 12'h070, 32'h00000000);
        rd("busy", 12'h06C, 32'h00000001);
        wr(12'h06C, 32'h00000001);
        wait_conv(1700, t0);
        rd("done", 12'h070, 32'h00000001);
        rd("result", 12'h074, 32'h0000005A);
        check("active", 32'(conversion_active), 32'h00000000);
        rd("status", 12'h080, 32'h00000003);
        check("irq", 32'(irq), 32'h00000001);
        wr(12'h084, 32'h00000000);
        @(posedge pclk);
        check("irq", 32'(irq), 32'h00000000);
        wr(12'h084, 32'h00000001);
        @(posedge pclk);
        check("irq", 32'(irq), 32'h00000001);
        wr(12'h088, 32'h00000003);
        rd("status", 12'h080, 32'h00000000);
        check("irq", 32'(irq), 32'h00000000);
    endtask : t_fast

    task automatic t_slow;
        int t0;
        sample_code <= 8'hC3;
        wr(12'h06C, 32'h00000003);
        t0 = cycles;
        check("rate", 32'(monitor_rate_select), 32'h00000001);
        rd("ctrl", 12'h06C, 32'h00000003);
        wait_conv(13600, t0);
        rd("result", 12'h074, 32'h000000C3);
    endtask : t_slow

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_trim();
        t_fast();
        t_slow();
        final_report();
    end
endmodule : monitor_converter_and_output_trim_test

`default_nettype wire

// File: hdl/mon_pkg.sv
package mon_pkg;

    // Clock rates in kHz; the divider counts are derived from them.
    localparam int unsigned CLK_KHZ = 200000;
    localparam int unsigned FAST_KHZ = 2000;
    localparam int unsigned SLOW_KHZ = 250;
    localparam int unsigned FAST_DIV = CLK_KHZ / FAST_KHZ;
    localparam int unsigned SLOW_DIV = CLK_KHZ / SLOW_KHZ;
    localparam int unsigned DIV_W = 10;
    localparam logic [DIV_W-1:0] FAST_LAST = DIV_W'(FAST_DIV - 1);
    localparam logic [DIV_W-1:0] SLOW_LAST = DIV_W'(SLOW_DIV - 1);

    // Conversion length in monitor converter clock cycles.
    localparam int unsigned CONV_TICKS = 17;
    localparam int unsigned CNT_W = 5;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_TICKS - 1);

    // Register indices; the byte address is four times the index.
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned IDX_W = 8;
    localparam logic [IDX_W-1:0] IDX_CM_TRIM = 8'h18;
    localparam logic [IDX_W-1:0] IDX_OFFSET_TRIM = 8'h19;
    localparam logic [IDX_W-1:0] IDX_CONV_CTRL = 8'h1B;
    localparam logic [IDX_W-1:0] IDX_CONV_DONE = 8'h1C;
    localparam logic [IDX_W-1:0] IDX_CONV_RESULT = 8'h1D;
    localparam logic [IDX_W-1:0] IDX_EV_STATUS = 8'h20;
    localparam logic [IDX_W-1:0] IDX_EV_ENABLE = 8'h21;
    localparam logic [IDX_W-1:0] IDX_EV_CLEAR = 8'h22;

    // Field layout.
    localparam int unsigned CM_W = 4;
    localparam int unsigned CODE_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned GO_BIT = 0;
    localparam int unsigned RATE_BIT = 1;
    localparam int unsigned DONE_BIT = 0;
    localparam int unsigned EV_W = 2;
    localparam int unsigned EV_DONE = 0;
    localparam int unsigned EV_REFUSED = 1;

    // Reset values.
    localparam logic [CM_W-1:0] CM_RESET = 4'h0;
    localparam logic [CODE_W-1:0] OFFSET_RESET = 8'hA0;
    localparam logic RATE_RESET = 1'h0;
    localparam logic DONE_RESET = 1'h1;
    localparam logic [CODE_W-1:0] RESULT_RESET = 8'hBD;
    localparam logic [EV_W-1:0] EV_RESET = 2'h0;

    typedef enum logic {
        CONV_IDLE = 1'b0,
        CONV_RUN = 1'b1
    } conv_state_e;

    typedef struct packed {
        logic [CM_W-1:0] amp_input_cm_current;
        logic [CODE_W-1:0] output_dc_offset_trim;
    } trim_s;

    typedef struct packed {
        logic [DIV_W-1:0] count;
        logic tick;
    } div_state_s;

    typedef struct packed {
        logic [CODE_W-1:0] meta;
        logic [CODE_W-1:0] stable;
    } sync_state_s;

    typedef struct packed {
        conv_state_e conv;
        logic [CNT_W-1:0] ticks;
        logic conv_rate;
        logic conversion_active;
        logic done;
        logic [CODE_W-1:0] result;
        trim_s trim;
        logic rate_sel;
        logic [EV_W-1:0] ev_status;
        logic [EV_W-1:0] ev_enable;
        logic irq;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } top_state_s;

endpackage : mon_pkg

// File: hdl/monitor_converter_and_output_trim.sv
// What this block does
// - Writing one to the start bit of the control register begins a conversion when idle.
// - A conversion completes seventeen monitor converter clock cycles after start.
// - Rate bit zero selects 2 MHz, one selects 250 kHz; resets to zero.
// - The completion flag reads zero throughout a conversion in progress.
// - Completion flag is read-only bit zero, one after reset and after completion.
// - Result register captures the sample at conversion end; resets to 0xBD.
// - Result is an unsigned 8-bit code of the sensor voltage, full scale 255.
// - Four-bit common-mode current field resets to zero, linear current setting.
// - Eight-bit output offset trim resets to 0xA0, linear offset adjustment.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module monitor_converter_and_output_trim (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mon_pkg::ADDR_W-1:0] paddr,
    input wire logic [mon_pkg::DATA_W-1:0] pwdata,
    output logic [mon_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [mon_pkg::CODE_W-1:0] sample_code,
    output mon_pkg::trim_s trim,
    output logic monitor_rate_select,
    output logic conversion_active,
    output logic irq
);

    mon_pkg::top_state_s st;
    mon_pkg::top_state_s next_st;

    logic tick;
    logic [mon_pkg::CODE_W-1:0] sample_sync_code;
    logic setup;
    logic access;
    logic wr;
    logic rd_setup;
    logic start_req;
    logic start_ok;
    logic start_refused;
    logic conv_end;
    logic [mon_pkg::EV_W-1:0] ev_set;
    logic [mon_pkg::EV_W-1:0] ev_clr;

    // Word index of a byte address; upper bits must be zero to match.
    function automatic logic hit(
        input logic [mon_pkg::ADDR_W-1:0] addr,
        input logic [mon_pkg::IDX_W-1:0] index
    );
        logic ok;
        ok = (addr[1:0] == 2'h0)
            && (addr[mon_pkg::ADDR_W-1:2]
                == {{(mon_pkg::ADDR_W-2-mon_pkg::IDX_W){1'b0}}, index});
        return ok;
    endfunction : hit

    function automatic logic mapped(
        input logic [mon_pkg::ADDR_W-1:0] addr
    );
        logic ok;
        ok = hit(addr, mon_pkg::IDX_CM_TRIM)
            || hit(addr, mon_pkg::IDX_OFFSET_TRIM)
            || hit(addr, mon_pkg::IDX_CONV_CTRL)
            || hit(addr, mon_pkg::IDX_CONV_DONE)
            || hit(addr, mon_pkg::IDX_CONV_RESULT)
            || hit(addr, mon_pkg::IDX_EV_STATUS)
            || hit(addr, mon_pkg::IDX_EV_ENABLE)
            || hit(addr, mon_pkg::IDX_EV_CLEAR);
        return ok;
    endfunction : mapped

    // Read value of one register, with unused bits as zero.
    function automatic logic [mon_pkg::DATA_W-1:0] read_word(
        input logic [mon_pkg::ADDR_W-1:0] addr,
        input mon_pkg::top_state_s s
    );
        logic [mon_pkg::DATA_W-1:0] w;
        w = '0;
        if (hit(addr, mon_pkg::IDX_CM_TRIM)) begin
            w[mon_pkg::CM_W-1:0] = s.trim.amp_input_cm_current;
        end else if (hit(addr, mon_pkg::IDX_OFFSET_TRIM)) begin
            w[mon_pkg::CODE_W-1:0] = s.trim.output_dc_offset_trim;
        end else if (hit(addr, mon_pkg::IDX_CONV_CTRL)) begin
            w[mon_pkg::RATE_BIT] = s.rate_sel;
            w[mon_pkg::GO_BIT] = (s.conv == mon_pkg::CONV_RUN);
        end else if (hit(addr, mon_pkg::IDX_CONV_DONE)) begin
            w[mon_pkg::DONE_BIT] = s.done;
        end else if (hit(addr, mon_pkg::IDX_CONV_RESULT)) begin
            w[mon_pkg::CODE_W-1:0] = s.result;
        end else if (hit(addr, mon_pkg::IDX_EV_STATUS)) begin
            w[mon_pkg::EV_W-1:0] = s.ev_status;
        end else if (hit(addr, mon_pkg::IDX_EV_ENABLE)) begin
            w[mon_pkg::EV_W-1:0] = s.ev_enable;
        end else begin
            w = '0;
        end
        return w;
    endfunction : read_word

    monitor_rate_divider u_divider (
        .pclk(pclk),
        .presetn(presetn),
        .restart(start_ok),
        .slow(st.conv_rate),
        .tick(tick)
    );

    sample_sync u_sample_sync (
        .pclk(pclk),
        .presetn(presetn),
        .sample_in(sample_code),
        .sample_out(sample_sync_code)
    );

    // Bus phases. The slave answers in the first access cycle, so every
    // transfer is exactly one setup and one access cycle long.
    always_comb begin
        setup = psel && !penable;
        access = psel && penable && st.pready;
        wr = access && pwrite && !st.pslverr;
        rd_setup = setup && !pwrite;
    end

    // Start handling; a start written while busy is dropped and reported.
    always_comb begin
        start_req = wr && hit(paddr, mon_pkg::IDX_CONV_CTRL)
            && pwdata[mon_pkg::GO_BIT];
        start_ok = start_req && (st.conv == mon_pkg::CONV_IDLE);
        start_refused = start_req && (st.conv == mon_pkg::CONV_RUN);
        conv_end = (st.conv == mon_pkg::CONV_RUN) && tick
            && (st.ticks == mon_pkg::CONV_LAST);
    end

    always_comb begin
        ev_set = '0;
        ev_set[mon_pkg::EV_DONE] = conv_end;
        ev_set[mon_pkg::EV_REFUSED] = start_refused;
        ev_clr = '0;
        if (wr && hit(paddr, mon_pkg::IDX_EV_CLEAR)) begin
            ev_clr = pwdata[mon_pkg::EV_W-1:0];
        end
    end

    always_comb begin
        next_st = st;

        // Register answers.
        next_st.pready = setup;
        if (setup) begin
            next_st.pslverr = !mapped(paddr);
            next_st.prdata = '0;
            if (rd_setup) begin
                next_st.prdata = read_word(paddr, st);
            end
        end else begin
            next_st.pslverr = 1'b0;
        end

        // Trim, rate and event enable writes.
        if (wr && hit(paddr, mon_pkg::IDX_CM_TRIM)) begin
            next_st.trim.amp_input_cm_current =
                pwdata[mon_pkg::CM_W-1:0];
        end
        if (wr && hit(paddr, mon_pkg::IDX_OFFSET_TRIM)) begin
            next_st.trim.output_dc_offset_trim =
                pwdata[mon_pkg::CODE_W-1:0];
        end
        if (wr && hit(paddr, mon_pkg::IDX_CONV_CTRL)) begin
            next_st.rate_sel = pwdata[mon_pkg::RATE_BIT];
        end
        if (wr && hit(paddr, mon_pkg::IDX_EV_ENABLE)) begin
            next_st.ev_enable = pwdata[mon_pkg::EV_W-1:0];
        end

        // Conversion sequencer.
        case (st.conv)
            mon_pkg::CONV_IDLE: begin
                if (start_ok) begin
                    next_st.conv = mon_pkg::CONV_RUN;
                    next_st.ticks = '0;
                    // The rate written with the start bit takes effect
                    // for this conversion; later writes change monitor_rate_select at once but never the divider.
                    next_st.conv_rate = pwdata[mon_pkg::RATE_BIT];
                    next_st.done = 1'b0;
                    next_st.conversion_active = 1'b1;
                end
            end
            mon_pkg::CONV_RUN: begin
                if (conv_end) begin
                    next_st.conv = mon_pkg::CONV_IDLE;
                    next_st.done = 1'b1;
                    next_st.result = sample_sync_code;
                    next_st.conversion_active = 1'b0;
                end else if (tick) begin
                    next_st.ticks = st.ticks + 1'b1;
                end
            end
            default: begin
                next_st.conv = mon_pkg::CONV_IDLE;
                next_st.done = 1'b1;
                next_st.conversion_active = 1'b0;
            end
        endcase

        // Sticky events: a set in the same cycle as its clear wins.
        next_st.ev_status = (st.ev_status & ~ev_clr) | ev_set;
        next_st.irq = |(next_st.ev_status & next_st.ev_enable);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.conv <= mon_pkg::CONV_IDLE;
            st.ticks <= '0;
            st.conv_rate <= mon_pkg::RATE_RESET;
            st.conversion_active <= 1'b0;
            st.done <= mon_pkg::DONE_RESET;
            st.result <= mon_pkg::RESULT_RESET;
            st.trim.amp_input_cm_current <= mon_pkg::CM_RESET;
            st.trim.output_dc_offset_trim <= mon_pkg::OFFSET_RESET;
            st.rate_sel <= mon_pkg::RATE_RESET;
            st.ev_status <= mon_pkg::EV_RESET;
            st.ev_enable <= mon_pkg::EV_RESET;
            st.irq <= 1'b0;
            st.pready <= 1'b0;
            st.pslverr <= 1'b0;
            st.prdata <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign trim = st.trim;
    assign monitor_rate_select = st.rate_sel;
    assign conversion_active = st.conversion_active;
    assign irq = st.irq;

endmodule : monitor_converter_and_output_trim

`default_nettype wire

// File: hdl/monitor_rate_divider.sv
`timescale 1ns/1ps
`default_nettype none

module monitor_rate_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic slow,
    output logic tick
);

    mon_pkg::div_state_s st;
    mon_pkg::div_state_s next_st;
    logic [mon_pkg::DIV_W-1:0] last;

    always_comb begin
        next_st = st;
        last = slow ? mon_pkg::SLOW_LAST : mon_pkg::FAST_LAST;
        next_st.tick = 1'b0;
        // Restart aligns the period so a conversion sees whole cycles.
        if (restart) begin
            next_st.count = '0;
        end else if (st.count >= last) begin
            next_st.count = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.count = st.count + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule : monitor_rate_divider

`default_nettype wire

// File: hdl/sample_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sample_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [mon_pkg::CODE_W-1:0] sample_in,
    output logic [mon_pkg::CODE_W-1:0] sample_out
);

    mon_pkg::sync_state_s st;
    mon_pkg::sync_state_s next_st;

    // The analog code settles long before a conversion ends, so a plain
    // two-stage bus synchroniser is enough here.
    always_comb begin
        next_st = st;
        next_st.meta = sample_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sample_out = st.stable;

endmodule : sample_sync

`default_nettype wire
